/* File: rtl/mss_defines.svh */
`ifndef MSS_DEFINES_SVH
`define MSS_DEFINES_SVH

// Timebase
`define MSS_CLK_PERIOD_NS 10
`define MSS_MS_NS 1000000
`define MSS_HOUR_S 3600
`define MSS_MS_PER_S 17'd1000
`define MSS_FBK_LIMIT_MS 11'd1000
`define MSS_GAP_MS 17'd20
`define MSS_DRV_PWR_MS 17'd1000
`define MSS_SPH_DEPTH 6'd40

// Register byte offsets
`define MSS_REG_CTRL 8'h00
`define MSS_REG_TIME 8'h04
`define MSS_REG_STAT 8'h08
`define MSS_REG_IRQ_STAT 8'h0c
`define MSS_REG_IRQ_MASK 8'h10

// Control fields
`define MSS_CTRL_MODE_LSB 0
`define MSS_CTRL_ORDER_BIT 2
`define MSS_CTRL_START_BIT 3
`define MSS_CTRL_STOP_BIT 4

// Timing fields, seconds and starts per hour
`define MSS_TIME_DLY_LSB 0
`define MSS_TIME_RUP_LSB 8
`define MSS_TIME_RDN_LSB 16
`define MSS_TIME_SPH_LSB 24

// Status fields
`define MSS_STAT_STATE_LSB 0
`define MSS_STAT_RELAY_LSB 4
`define MSS_STAT_FBK_LSB 8
`define MSS_STAT_CNT_LSB 16

// Interrupt bits
`define MSS_IRQ_OPEN 0
`define MSS_IRQ_WELD 1
`define MSS_IRQ_DSTART 2
`define MSS_IRQ_DSTOP 3
`define MSS_IRQ_REFUSE 4

// Reset values
`define MSS_TIME_RST 32'h0a0a_0a05
`define MSS_MASK_RST 5'h00

// Bus answers
`define MSS_RESP_OKAY 2'h0
`define MSS_RESP_SLVERR 2'h2

`endif

/* File: rtl/mss_pkg.sv */
package mss_pkg;

  typedef enum logic [1:0] {
    MSS_MODE_OFF = 2'b00,
    MSS_MODE_RESIST = 2'b01,
    MSS_MODE_DRIVE = 2'b10,
    MSS_MODE_AUTO = 2'b11
  } mss_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_R_STAGE1 = 4'b0001,
    ST_R_RUN = 4'b0010,
    ST_D_POWER = 4'b0011,
    ST_D_RAMP = 4'b0100,
    ST_D_RUN = 4'b0101,
    ST_D_STOP = 4'b0110,
    ST_T_FIRST = 4'b0111,
    ST_T_CHG = 4'b1000,
    ST_T_GAP = 4'b1001,
    ST_T_RUN = 4'b1010
  } mss_state_t;

  typedef struct packed {
    logic aux;
    logic b;
    logic a;
  } mss_relay_t;

  typedef struct packed {
    logic trip;
    logic stop;
    logic start;
  } mss_cmd_t;

endpackage

/* File: rtl/mss_tick.sv */
`timescale 1ns/10ps
`include "mss_defines.svh"
module mss_tick #(
  parameter logic [16:0] TICK_CYCLES = 17'd100000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Millisecond strobe
  output logic tick_ff
);
  logic [16:0] cnt_ff;
  logic [16:0] nxt_cnt;
  logic nxt_tick;

  assign nxt_tick = (cnt_ff == TICK_CYCLES - 17'd1);
  assign nxt_cnt = nxt_tick ? 17'd0 : cnt_ff + 17'd1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 17'd0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end
endmodule

/* File: rtl/mss_fbk.sv */
`timescale 1ns/10ps
`include "mss_defines.svh"
module mss_fbk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Timebase and enable
  input wire logic tick,
  input wire logic enable,
  // Relay and its feedback contact
  input wire logic relay,
  input wire logic status,
  // One-cycle fault events
  output logic open_evt_ff,
  output logic weld_evt_ff
);
  logic [10:0] ms_ff;
  logic [10:0] nxt_ms;
  logic relay_q_ff;
  logic mismatch;
  logic fire;

  // Fresh relay change restarts the one second window
  assign mismatch = enable & (relay ^ status) & (relay == relay_q_ff);
  assign fire = mismatch & tick & (ms_ff == `MSS_FBK_LIMIT_MS - 11'd1);
  assign nxt_ms = !mismatch ? 11'd0 :
                  (tick && ms_ff != `MSS_FBK_LIMIT_MS) ? ms_ff + 11'd1 : ms_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_ff <= 11'd0;
      relay_q_ff <= 1'b0;
      open_evt_ff <= 1'b0;
      weld_evt_ff <= 1'b0;
    end else begin
      ms_ff <= nxt_ms;
      relay_q_ff <= relay;
      open_evt_ff <= fire & relay;
      weld_evt_ff <= fire & ~relay;
    end
  end
endmodule

/* File: rtl/mss_sequencer.sv */
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "mss_defines.svh"
module mss_sequencer #(
  parameter logic [16:0] MS_TICK_CYCLES = 17'(`MSS_MS_NS / `MSS_CLK_PERIOD_NS),
  parameter logic [21:0] HOUR_MS = 22'(`MSS_HOUR_S) * 22'(`MSS_MS_PER_S)
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Command and feedback pins
  input wire mss_pkg::mss_cmd_t cmd_pin,
  input wire mss_pkg::mss_relay_t status_pin,
  // Relay coils and interrupt
  output mss_pkg::mss_relay_t relay_ff,
  output logic irq_ff
);
  import mss_pkg::*;

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic ms_hit(input logic [16:0] now, input logic [16:0] lim, input logic tk);
    return tk & (now == lim - 17'd1);
  endfunction

  function automatic logic [5:0] ptr_inc(input logic [5:0] p);
    return (p == `MSS_SPH_DEPTH - 6'd1) ? 6'd0 : p + 6'd1;
  endfunction

  // Pin synchronisers
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic start_q_ff;
  mss_cmd_t cmd_s;
  mss_relay_t fbk_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
      start_q_ff <= 1'b0;
    end else begin
      sync1_ff <= {status_pin, cmd_pin};
      sync2_ff <= sync1_ff;
      start_q_ff <= cmd_s.start;
    end
  end
  assign cmd_s = sync2_ff[2:0];
  assign fbk_s = sync2_ff[5:3];

  // Millisecond timebase
  logic tick;
  mss_tick #(.TICK_CYCLES(MS_TICK_CYCLES)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_ff(tick)
  );

  // Register bus slave
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic wr_go;
  logic wr_hit;
  logic [7:0] wr_a;
  logic [7:0] rd_a;
  logic wr_ctrl;
  logic wr_time;
  logic wr_istat;
  logic wr_mask;
  logic [31:0] wr_ctrl_val;
  logic [31:0] w1c_val;

  assign wr_go = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  assign wr_a = {aw_addr_ff[7:2], 2'b00};
  assign rd_a = {s_axi_araddr[7:2], 2'b00};
  assign wr_ctrl = wr_go & (wr_a == `MSS_REG_CTRL);
  assign wr_time = wr_go & (wr_a == `MSS_REG_TIME);
  assign wr_istat = wr_go & (wr_a == `MSS_REG_IRQ_STAT);
  assign wr_mask = wr_go & (wr_a == `MSS_REG_IRQ_MASK);
  assign wr_hit = wr_ctrl | wr_time | wr_istat | wr_mask | (wr_a == `MSS_REG_STAT);
  assign wr_ctrl_val = merge_strb(32'h0000_0000, w_data_ff, w_strb_ff);
  assign w1c_val = wr_istat ? merge_strb(32'h0000_0000, w_data_ff, w_strb_ff) : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MSS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `MSS_RESP_OKAY : `MSS_RESP_SLVERR;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Ready falls once the item is held, rises after the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~(aw_got_ff | (s_axi_awvalid & s_axi_awready)) & ~s_axi_bvalid & ~wr_go;
      s_axi_wready <= ~(w_got_ff | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid & ~wr_go;
    end
  end

  // Control and timing registers
  mss_mode_t mode_ff;
  logic order_ff;
  logic [31:0] time_ff;
  logic [4:0] mask_ff;
  logic [4:0] irq_stat_ff;
  logic [4:0] nxt_irq_stat;
  logic [4:0] events;
  logic [16:0] dly_ms;
  logic [16:0] rup_ms;
  logic [16:0] rdn_ms;
  logic [5:0] sph_lim;
  logic [31:0] mask_new;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= MSS_MODE_OFF;
      order_ff <= 1'b0;
      time_ff <= `MSS_TIME_RST;
      mask_ff <= `MSS_MASK_RST;
    end else begin
      if (wr_ctrl && w_strb_ff[0]) begin
        mode_ff <= mss_mode_t'(wr_ctrl_val[`MSS_CTRL_MODE_LSB +: 2]);
        order_ff <= wr_ctrl_val[`MSS_CTRL_ORDER_BIT];
      end
      if (wr_time) begin
        time_ff <= merge_strb(time_ff, w_data_ff, w_strb_ff);
      end
      if (wr_mask) begin
        mask_ff <= mask_new[4:0];
      end
    end
  end
  assign mask_new = merge_strb({27'h0, mask_ff}, w_data_ff, w_strb_ff);
  assign dly_ms = {10'h000, time_ff[`MSS_TIME_DLY_LSB +: 7]} * `MSS_MS_PER_S;
  assign rup_ms = {10'h000, time_ff[`MSS_TIME_RUP_LSB +: 7]} * `MSS_MS_PER_S;
  assign rdn_ms = {10'h000, time_ff[`MSS_TIME_RDN_LSB +: 7]} * `MSS_MS_PER_S;
  assign sph_lim = time_ff[`MSS_TIME_SPH_LSB +: 6];

  // Commands
  logic sw_start;
  logic sw_stop;
  logic stop_trip;
  logic start_req;
  logic sph_full;
  logic start_go;
  logic refused;
  mss_state_t state_ff;

  assign sw_start = wr_ctrl & wr_ctrl_val[`MSS_CTRL_START_BIT];
  assign sw_stop = wr_ctrl & wr_ctrl_val[`MSS_CTRL_STOP_BIT];
  assign stop_trip = cmd_s.stop | cmd_s.trip | sw_stop;
  assign start_req = (cmd_s.start & ~start_q_ff) | sw_start;
  assign start_go = start_req & (state_ff == ST_IDLE) & ~stop_trip & (mode_ff != MSS_MODE_OFF) &
                    ~((mode_ff == MSS_MODE_AUTO) & sph_full);
  assign refused = start_req & (state_ff == ST_IDLE) & ~stop_trip & (mode_ff == MSS_MODE_AUTO) & sph_full;

  // Autotransformer starts in the last hour, one timestamp per start
  logic [21:0] ts_mem [0:39];
  logic [21:0] now_ms_ff;
  logic [5:0] wr_ptr_ff;
  logic [5:0] rd_ptr_ff;
  logic [5:0] starts_cnt_ff;
  logic push;
  logic expire_old;
  logic [21:0] age;

  assign push = start_go & (mode_ff == MSS_MODE_AUTO);
  assign age = now_ms_ff - ts_mem[rd_ptr_ff];
  assign expire_old = tick & (starts_cnt_ff != 6'd0) & (age >= HOUR_MS);
  assign sph_full = (starts_cnt_ff >= sph_lim) | (starts_cnt_ff == `MSS_SPH_DEPTH);

  always_ff @(posedge aclk) begin
    if (push) begin
      ts_mem[wr_ptr_ff] <= now_ms_ff;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      now_ms_ff <= 22'h000000;
      wr_ptr_ff <= 6'd0;
      rd_ptr_ff <= 6'd0;
      starts_cnt_ff <= 6'd0;
    end else begin
      now_ms_ff <= tick ? now_ms_ff + 22'h000001 : now_ms_ff;
      wr_ptr_ff <= push ? ptr_inc(wr_ptr_ff) : wr_ptr_ff;
      rd_ptr_ff <= expire_old ? ptr_inc(rd_ptr_ff) : rd_ptr_ff;
      starts_cnt_ff <= starts_cnt_ff + {5'h00, push} - {5'h00, expire_old};
    end
  end

  // Feedback supervision per relay
  logic [2:0] fbk_en;
  logic [2:0] open_evt;
  logic [2:0] weld_evt;
  logic open_any;
  logic weld_any;

  assign fbk_en[0] = (mode_ff != MSS_MODE_OFF);
  assign fbk_en[1] = (mode_ff == MSS_MODE_RESIST) | (mode_ff == MSS_MODE_AUTO);
  assign fbk_en[2] = (mode_ff == MSS_MODE_AUTO);
  generate
    for (genvar gi = 0; gi < 3; gi++) begin : g_fbk
      mss_fbk u_fbk (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .enable(fbk_en[gi]),
        .relay(relay_ff[gi]),
        .status(fbk_s[gi]),
        .open_evt_ff(open_evt[gi]),
        .weld_evt_ff(weld_evt[gi])
      );
    end
  endgenerate
  assign open_any = |open_evt;
  assign weld_any = |weld_evt;

  // Sequencer
  mss_state_t nxt_state;
  mss_relay_t nxt_relay;
  logic [16:0] seq_ms_ff;
  logic [16:0] nxt_seq_ms;
  logic keep_ms;
  logic ds_fail;
  logic dstop_fail;
  logic drive_run;

  assign drive_run = (state_ff == ST_D_POWER) | (state_ff == ST_D_RAMP) | (state_ff == ST_D_RUN);

  always_comb begin
    nxt_state = state_ff;
    nxt_relay = relay_ff;
    keep_ms = 1'b0;
    ds_fail = 1'b0;
    dstop_fail = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (start_go && mode_ff == MSS_MODE_RESIST) begin
          nxt_state = ST_R_STAGE1;
          nxt_relay.a = 1'b1;
        end else if (start_go && mode_ff == MSS_MODE_DRIVE) begin
          nxt_state = ST_D_POWER;
          nxt_relay.a = 1'b1;
        end else if (start_go && mode_ff == MSS_MODE_AUTO) begin
          nxt_state = ST_T_FIRST;
          nxt_relay.a = ~order_ff;
          nxt_relay.aux = order_ff;
        end
      end
      ST_R_STAGE1: begin
        if (ms_hit(seq_ms_ff, dly_ms, tick)) begin
          nxt_state = ST_R_RUN;
          nxt_relay.b = 1'b1;
        end
      end
      ST_D_POWER: begin
        if (ms_hit(seq_ms_ff, `MSS_DRV_PWR_MS, tick)) begin
          nxt_state = ST_D_RAMP;
          nxt_relay.b = 1'b1;
        end
      end
      ST_D_RAMP: begin
        if (fbk_s.b) begin
          nxt_state = ST_D_RUN;
        end else begin
          ds_fail = ms_hit(seq_ms_ff, rup_ms, tick);
        end
      end
      ST_D_STOP: begin
        if (!fbk_s.b) begin
          nxt_state = ST_IDLE;
          nxt_relay.a = 1'b0;
        end else begin
          dstop_fail = ms_hit(seq_ms_ff, rdn_ms, tick);
        end
      end
      ST_T_FIRST: begin
        if (ms_hit(seq_ms_ff, `MSS_GAP_MS, tick)) begin
          nxt_state = ST_T_CHG;
          nxt_relay.a = 1'b1;
          nxt_relay.aux = 1'b1;
          keep_ms = ~order_ff;
        end
      end
      ST_T_CHG: begin
        if (ms_hit(seq_ms_ff, dly_ms, tick)) begin
          nxt_state = ST_T_GAP;
          nxt_relay.a = 1'b0;
          nxt_relay.aux = 1'b0;
        end
      end
      ST_T_GAP: begin
        if (ms_hit(seq_ms_ff, `MSS_GAP_MS, tick)) begin
          nxt_state = ST_T_RUN;
          nxt_relay.b = 1'b1;
        end
      end
      ST_R_RUN, ST_D_RUN, ST_T_RUN: begin
        nxt_state = state_ff;
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_relay = 3'b000;
      end
    endcase
    if (stop_trip && drive_run) begin
      nxt_state = ST_D_STOP;
      nxt_relay.b = 1'b0;
    end else if (stop_trip && state_ff != ST_IDLE && state_ff != ST_D_STOP) begin
      nxt_state = ST_IDLE;
      nxt_relay = 3'b000;
    end
    if (open_any) begin
      nxt_state = ST_IDLE;
      nxt_relay = 3'b000;
    end
    keep_ms = keep_ms & (nxt_state == ST_T_CHG);
  end

  // Sequence timer restarts on every state change except ST_T_FIRST to ST_T_CHG with order_ff low
  assign nxt_seq_ms = ((nxt_state != state_ff) && !keep_ms) ? 17'd0 :
                      (tick && seq_ms_ff != 17'h1ffff) ? seq_ms_ff + 17'd1 : seq_ms_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_IDLE;
      relay_ff <= 3'b000;
      seq_ms_ff <= 17'd0;
    end else begin
      state_ff <= nxt_state;
      relay_ff <= nxt_relay;
      seq_ms_ff <= nxt_seq_ms;
    end
  end

  // Sticky events, set wins over clear
  assign events = {refused, dstop_fail, ds_fail, weld_any, open_any};
  assign nxt_irq_stat = (irq_stat_ff & ~w1c_val[4:0]) | events;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= 5'h00;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(irq_stat_ff & mask_ff);
    end
  end

  // Read path
  assign rd_hit = (rd_a == `MSS_REG_CTRL) | (rd_a == `MSS_REG_TIME) | (rd_a == `MSS_REG_STAT) |
                  (rd_a == `MSS_REG_IRQ_STAT) | (rd_a == `MSS_REG_IRQ_MASK);
  assign rd_mux = (rd_a == `MSS_REG_CTRL) ? {29'h0, order_ff, mode_ff} :
                  (rd_a == `MSS_REG_TIME) ? time_ff :
                  (rd_a == `MSS_REG_STAT) ? ({26'h0, starts_cnt_ff} << `MSS_STAT_CNT_LSB) |
                                            ({29'h0, fbk_s} << `MSS_STAT_FBK_LSB) |
                                            ({29'h0, relay_ff} << `MSS_STAT_RELAY_LSB) |
                                            ({28'h0, state_ff} << `MSS_STAT_STATE_LSB) :
                  (rd_a == `MSS_REG_IRQ_STAT) ? {27'h0, irq_stat_ff} :
                  (rd_a == `MSS_REG_IRQ_MASK) ? {27'h0, mask_ff} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MSS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? `MSS_RESP_OKAY : `MSS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_STOP_RESIST: assert property ((state_ff inside {ST_R_STAGE1, ST_R_RUN}) && stop_trip
    |=> relay_ff == 3'b000)
    else $error("resistance stop left a relay closed");
  AST_OPEN_RESIST: assert property (open_any && mode_ff == MSS_MODE_RESIST
    |=> irq_stat_ff[`MSS_IRQ_OPEN] && relay_ff == 3'b000)
    else $error("open circuit did not alarm and open relays");
  AST_WELD_ALARM: assert property (weld_any |=> irq_stat_ff[`MSS_IRQ_WELD])
    else $error("welded contact not flagged");
  AST_RESIST_ORDER: assert property (mode_ff == MSS_MODE_RESIST && relay_ff.b |-> relay_ff.a)
    else $error("second relay closed without first");
  AST_STAGE_DELAY: assert property ($rose(relay_ff.b) && state_ff == ST_R_RUN
    |-> $past(seq_ms_ff) == dly_ms - 17'd1)
    else $error("stage delay wrong");
  AST_DRIVE_POWER: assert property ($rose(relay_ff.b) && state_ff == ST_D_RAMP
    |-> relay_ff.a && $past(seq_ms_ff) == 17'd999)
    else $error("drive run before one second of power");
  AST_DRIVE_START_FAIL: assert property (state_ff == ST_D_RAMP && !fbk_s.b && ms_hit(seq_ms_ff, rup_ms, tick)
    |=> irq_stat_ff[`MSS_IRQ_DSTART])
    else $error("drive start failure missed");
  AST_DRIVE_STOP: assert property (state_ff == ST_D_STOP |-> !relay_ff.b && relay_ff.a)
    else $error("drive stop relay order wrong");
  AST_AUTO_FIRST: assert property (state_ff == ST_T_FIRST
    |-> relay_ff.a != relay_ff.aux && relay_ff.aux == order_ff)
    else $error("autotransformer first relay wrong");
  AST_AUTO_GAP: assert property (state_ff == ST_T_CHG ##1 state_ff == ST_T_GAP
    |-> relay_ff == 3'b000 ##20 state_ff != ST_T_RUN)
    else $error("changeover gap wrong");
  AST_START_LIMIT: assert property (push |-> starts_cnt_ff < sph_lim ##1 starts_cnt_ff <= sph_lim)
    else $error("start accepted at limit");
  AST_TIMER_CLEAR: assert property (stop_trip && !drive_run && state_ff != ST_IDLE && state_ff != ST_D_STOP
    |=> seq_ms_ff == 17'd0)
    else $error("timer not cleared on stop");

  COV_RESIST_RUN: cover property (state_ff == ST_R_STAGE1 ##1 state_ff == ST_R_RUN);
  COV_DRIVE_RUN: cover property (state_ff == ST_D_RAMP ##1 state_ff == ST_D_RUN);
  COV_AUTO_RUN: cover property (state_ff == ST_T_GAP ##1 state_ff == ST_T_RUN);
  COV_REFUSED: cover property (refused);
endmodule

/* File: dv/mss_contactor_model.sv */
`timescale 1ns/10ps
module mss_contactor_model (
  // Clock
  input wire logic aclk,
  // Coils and injected faults
  input wire mss_pkg::mss_relay_t coil,
  input wire logic [2:0] no_fbk,
  input wire logic [2:0] stuck,
  // Feedback contacts
  output mss_pkg::mss_relay_t fbk
);
  import mss_pkg::*;
  logic [89:0] sh_ff = '0;
  // Contacts and drive answer 3 ms after the coil moves
  always @(posedge aclk) begin
    sh_ff <= {sh_ff[86:0], coil};
  end
  assign fbk = (sh_ff[89:87] & ~no_fbk) | stuck;
endmodule

/* File: dv/tb_mss_sequencer.sv */
`timescale 1ns/10ps
module tb_mss_sequencer;
  import mss_pkg::*;
  logic aclk = 0, aresetn = 0, probe = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'h4a3a3657;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_ff;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  mss_cmd_t cmd_pin = '0;
  mss_relay_t relay_ff, status_pin;
  logic [2:0] no_fbk = '0, stuck = '0;
  logic [33:0] bus_q[$];
  logic [3:0] pin_q[$];
  int error_cnt = 0, checked = 0, cyc = 0;

  always #5 aclk = ~aclk;

  mss_sequencer #(.MS_TICK_CYCLES(17'd10), .HOUR_MS(22'd3000)) mss_sequencer_i (.*);
  mss_contactor_model mss_contactor_model_i (.aclk(aclk), .coil(relay_ff), .no_fbk(no_fbk), .stuck(stuck),
    .fbk(status_pin));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task chk(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Retire the oldest note whenever an answer or a probe shows up
  always @(posedge aclk) begin
    cyc++;
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, bus_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, bus_q.pop_front());
    if (probe) chk({30'h0, irq_ff, relay_ff}, {30'h0, pin_q.pop_front()});
    if (cyc == 95000) begin
      error_cnt++;
      give_verdict;
    end
  end

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bus_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask

  task rd(input logic [7:0] a, input logic [33:0] e);
    bus_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask

  // Mode is written first: a start only sees the mode already held
  task go(input logic [31:0] m);
    wr(8'h00, m, 2'h0);
    wr(8'h00, m | 32'h8, 2'h0);
  endtask

  task ms(input int n);
    repeat (n * 10) @(posedge aclk);
  endtask

  // Expected {irq, aux, b, a}
  task look(input logic [3:0] e);
    pin_q.push_back(e);
    probe <= 1;
    @(posedge aclk);
    probe <= 0;
  endtask

  // Stop or trip, picked at random
  task halt(input logic [3:0] e1, input logic [3:0] e2);
    seed = xs(seed);
    cmd_pin <= seed[0] ? 3'b100 : 3'b010;
    ms(1);
    look(e1);
    ms(4);
    look(e2);
    cmd_pin <= '0;
    ms(5);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    rd(8'h04, {2'h0, 32'h0a0a0a05});
    rd(8'h14, {2'h2, 32'h0});
    wr(8'h14, 32'h1, 2'h2);
    seed = xs(seed);
    wr(8'h10, seed, 2'h0);
    rd(8'h10, {2'h0, 27'h0, seed[4:0]});
    wr(8'h10, 32'h1f, 2'h0);
    wr(8'h04, 32'h02010101, 2'h0);
    $display("registers done");
    go(32'h01);
    ms(5);
    look(4'b0001);
    ms(985);
    look(4'b0001);
    ms(20);
    look(4'b0011);
    halt(4'b0000, 4'b0000);
    $display("resistance start done");
    go(32'h02);
    ms(5);
    look(4'b0001);
    ms(985);
    look(4'b0001);
    ms(20);
    look(4'b0011);
    halt(4'b0001, 4'b0000);
    rd(8'h0c, {2'h0, 32'h0});
    $display("drive start done");
    no_fbk <= 3'b001;
    go(32'h01);
    ms(1010);
    look(4'b1000);
    rd(8'h0c, {2'h0, 32'h1});
    no_fbk <= '0;
    wr(8'h10, 32'h0, 2'h0);
    ms(1);
    look(4'b0000);
    wr(8'h0c, 32'h1, 2'h0);
    wr(8'h10, 32'h1f, 2'h0);
    ms(1);
    look(4'b0000);
    stuck <= 3'b001;
    ms(1010);
    stuck <= '0;
    rd(8'h0c, {2'h0, 32'h2});
    wr(8'h0c, 32'h2, 2'h0);
    $display("feedback alarms done");
    no_fbk <= 3'b010;
    go(32'h02);
    ms(2010);
    look(4'b1011);
    rd(8'h0c, {2'h0, 32'h4});
    wr(8'h0c, 32'h4, 2'h0);
    stuck <= 3'b010;
    cmd_pin <= 3'b010;
    ms(1010);
    look(4'b1001);
    rd(8'h0c, {2'h0, 32'h8});
    wr(8'h0c, 32'h8, 2'h0);
    no_fbk <= '0;
    stuck <= '0;
    cmd_pin <= '0;
    ms(5);
    look(4'b0000);
    $display("drive alarms done");
    go(32'h07);
    ms(5);
    look(4'b0100);
    ms(20);
    look(4'b0101);
    halt(4'b0000, 4'b0000);
    go(32'h03);
    ms(5);
    look(4'b0001);
    ms(20);
    look(4'b0101);
    ms(985);
    look(4'b0000);
    ms(20);
    look(4'b0010);
    halt(4'b0000, 4'b0000);
    go(32'h03);
    ms(5);
    look(4'b1000);
    rd(8'h0c, {2'h0, 32'h10});
    $display("autotransformer done");
    give_verdict;
  end
endmodule
